// File: bench/gdmp_board.sv
// Board model: resolves each pin from the driver controls and an outside level.
// Assumes one instance per port; undriven pins without pull-up show ext_i.
`timescale 1ns/10ps
module gdmp_board (
  // Driver controls
  input  logic [7:0] o_i,
  input  logic [7:0] oe_i,
  input  logic [7:0] pu_i,
  // Outside level
  input  logic [7:0] ext_i,
  // Pin level
  output logic [7:0] lvl_o
);
  assign lvl_o = (oe_i & o_i) | (~oe_i & (pu_i | ext_i));
endmodule

// File: bench/gdmp_gpio_asserts.sv
// Checker of bus answers and port A driver controls.
// Assumes binding onto gdmp_gpio.
`timescale 1ns/10ps
module gdmp_gpio_asserts (
  // Clock, reset, bus
  input logic       core_clk_i,
  input logic       rst_n_i,
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_ack_o,
  input logic       wb_err_o,
  // Port A drivers
  input logic [7:0] port_a_pins_o,
  input logic [7:0] port_a_pins_oe_o,
  input logic [7:0] port_a_sink_lo_o,
  input logic [7:0] port_a_sink_med_o,
  input logic [7:0] port_a_sink_hi_o,
  input logic [7:0] port_a_src_o,
  input logic [7:0] port_a_pullup_o,
  input logic [7:0] port_a_ttl_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [7:0] snk = port_a_sink_lo_o | port_a_sink_med_o | port_a_sink_hi_o;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  sequence s_ans; (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o); endsequence
  property p_ans; s_req |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("bus answer not one pulse");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !(wb_ack_o || wb_err_o); endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_oe; port_a_pins_oe_o == (snk | port_a_src_o); endproperty
  a_oe: assert property (p_oe) else $error("enable mismatch");
  property p_one; ((port_a_sink_lo_o & (port_a_sink_med_o | port_a_sink_hi_o))
    | (port_a_sink_med_o & port_a_sink_hi_o) | (snk & port_a_src_o)
    | ((snk | port_a_src_o) & port_a_pullup_o)) == 8'h00; endproperty
  a_one: assert property (p_one) else $error("drivers overlap");
  property p_hd; port_a_pins_o == port_a_src_o; endproperty
  a_hd: assert property (p_hd) else $error("output level wrong");
  property p_ttl; (port_a_ttl_o & (snk | port_a_src_o | port_a_pullup_o)) == 8'h00; endproperty
  a_ttl: assert property (p_ttl) else $error("threshold wrong");
  property p_rst; $rose(rst_n_i) |-> port_a_pins_oe_o == 8'h00 && port_a_pullup_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_hold; !wb_ack_o |=> $stable(snk | port_a_src_o | port_a_pullup_o); endproperty
  a_hold: assert property (p_hold) else $error("drive changed without write");
endmodule
bind gdmp_gpio gdmp_gpio_asserts u_chk (.*);

// File: bench/gdmp_gpio_tb.sv
// Self-checking bench: bus tasks, full mode table on both ports, aux port, reset.
// Assumes gdmp_board models the pins' surroundings.
`timescale 1ns/10ps
module gdmp_gpio_tb;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, icm = 0, ps2 = 0, ab;
  logic        dp = 0, dm = 0, osc = 0, rgp = 0, ack, err;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0, dato, rd;
  logic [7:0]  ao, aoe, bo, boe, lva, lvb, ext = 8'h0F;
  logic [7:0]  s [12];
  logic [7:0]  e [6] = '{8'h04, 8'h02, 8'h08, 8'hA0, 8'h40, 8'h10};
  integer      miscompares = 0, total_checks = 0, cnt = 0, p;
  gdmp_gpio dut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dato),
    .wb_ack_o(ack), .wb_err_o(err), .int_clk_mode_i(icm), .ps2_mode_i(ps2),
    .port_a_pins_i(lva), .port_b_pins_i(lvb), .port_a_pins_o(ao), .port_b_pins_o(bo),
    .port_a_pins_oe_o(aoe), .port_b_pins_oe_o(boe), .port_a_sink_lo_o(s[0]),
    .port_a_sink_med_o(s[1]), .port_a_sink_hi_o(s[2]), .port_a_src_o(s[3]),
    .port_a_pullup_o(s[4]), .port_a_ttl_o(s[5]), .port_b_sink_lo_o(s[6]),
    .port_b_sink_med_o(s[7]), .port_b_sink_hi_o(s[8]), .port_b_src_o(s[9]),
    .port_b_pullup_o(s[10]), .port_b_ttl_o(s[11]), .usb_dp_pin_i(dp), .usb_dm_pin_i(dm),
    .oscillator_input_pin_i(osc), .regulator_output_pin_i(rgp));
  gdmp_board u_pa (.o_i(ao), .oe_i(aoe), .pu_i(s[4]), .ext_i(ext), .lvl_o(lva));
  gdmp_board u_pb (.o_i(bo), .oe_i(boe), .pu_i(s[10]), .ext_i(ext), .lvl_o(lvb));
  task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task acc(input logic w, input logic [7:0] ix, input logic [7:0] wd);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= {24'h0, wd};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    rd = dato;
    ab = err;
    cyc <= 0;
    stb <= 0;
  endtask
  task end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    cnt++;
    if (cnt == 5000)
    begin
      miscompares++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    chk(aoe | boe | s[5] | s[11], 0);
    acc(0, 8'h00, 8'h00); chk(rd, 32'h0F);
    for (p = 10; p < 14; p++)
    begin
      acc(1, p, 8'hFF); acc(0, p, 8'h00); chk(rd, 0);
    end
    acc(0, 8'h3F, 8'h00); chk(ab, 1);
    for (p = 0; p < 2; p++)
    begin
      acc(1, p, 8'hF0); acc(1, 8'h0B + 2 * p, 8'hCC); acc(1, 8'h0A + 2 * p, 8'hAA);
    end
    repeat (3) @(posedge clk);
    for (p = 0; p < 12; p++) chk(s[p], e[p % 6]);
    chk({aoe, ao, boe, bo}, 32'hAEA0AEA0);
    acc(0, 8'h00, 8'h00); chk(rd, 32'hE1);
    acc(0, 8'h01, 8'h00); chk(rd, 32'hE1);
    acc(1, 8'h00, 8'h00); acc(1, 8'h0B, 8'h00);
    repeat (3) @(posedge clk);
    chk({aoe, ao, s[1]}, {8'hAA, 8'h00, 8'hAA});
    acc(0, 8'h00, 8'h00); chk(rd, 32'h05);
    acc(1, 8'h0A, 8'h55);
    repeat (3) @(posedge clk);
    acc(0, 8'h00, 8'h00); chk(rd, 32'h0A);
    {dp, osc, rgp, icm, ps2} <= 5'h1F;
    repeat (3) @(posedge clk);
    acc(0, 8'h02, 8'h00); chk(rd, 32'h23);
    {icm, ps2, dm} <= 3'b001;
    repeat (3) @(posedge clk);
    acc(0, 8'h02, 8'h00); chk(rd, 32'h30);
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    chk({aoe, boe, s[5], s[11]}, 0);
    end_of_test;
  end
endmodule

// File: core/gdmp_gpio.v
// Two 8-bit GPIO ports with per-pin drive modes and an auxiliary input port.
// Assumes a classic Wishbone master on core_clk_i; pin levels are asynchronous.
`timescale 1ns/10ps
`include "gdmp_map.vh"

module gdmp_gpio #(
  parameter PORT_B_FULL = 1
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Mode inputs
  input  wire        int_clk_mode_i,
  input  wire        ps2_mode_i,
  // Port pins
  input  wire [7:0]  port_a_pins_i,
  input  wire [7:0]  port_b_pins_i,
  output reg  [7:0]  port_a_pins_o,
  output reg  [7:0]  port_b_pins_o,
  output reg  [7:0]  port_a_pins_oe_o,
  output reg  [7:0]  port_b_pins_oe_o,
  // Driver controls, per pin
  output reg  [7:0]  port_a_sink_lo_o,
  output reg  [7:0]  port_a_sink_med_o,
  output reg  [7:0]  port_a_sink_hi_o,
  output reg  [7:0]  port_a_src_o,
  output reg  [7:0]  port_a_pullup_o,
  output reg  [7:0]  port_a_ttl_o,
  output reg  [7:0]  port_b_sink_lo_o,
  output reg  [7:0]  port_b_sink_med_o,
  output reg  [7:0]  port_b_sink_hi_o,
  output reg  [7:0]  port_b_src_o,
  output reg  [7:0]  port_b_pullup_o,
  output reg  [7:0]  port_b_ttl_o,
  // Auxiliary input pins
  input  wire        usb_dp_pin_i,
  input  wire        usb_dm_pin_i,
  input  wire        oscillator_input_pin_i,
  input  wire        regulator_output_pin_i
);

  localparam [7:0] PB_MASK = PORT_B_FULL ? `GDMP_PORT_B_FULL_MASK : `GDMP_PORT_B_BASE_MASK;

  // Mode code: {data, sel_hi, sel_lo}
  localparam [2:0] M_SINK_LO  = 3'h2;
  localparam [2:0] M_SINK_MED = 3'h1;
  localparam [2:0] M_SINK_HI  = 3'h3;
  localparam [2:0] M_PULLUP   = 3'h6;
  localparam [2:0] M_TTL      = 3'h4;

  reg  [7:0] port_a_data_q;
  reg  [7:0] port_b_data_q;
  reg  [7:0] pa_sel_lo_q;
  reg  [7:0] pa_sel_hi_q;
  reg  [7:0] pb_sel_lo_q;
  reg  [7:0] pb_sel_hi_q;
  reg  [7:0] pa_s1_q;
  reg  [7:0] pa_s2_q;
  reg  [7:0] pb_s1_q;
  reg  [7:0] pb_s2_q;
  reg  [3:0] aux_s1_q;
  reg  [3:0] aux_s2_q;
  reg  [7:0] rd_d;
  reg        hit_d;
  reg  [7:0] aux_d;
  wire [7:0] idx;
  wire       req;
  wire       wr;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr  = req & wb_we_i & wb_sel_i[0];

  // Per-pin driver decode; returns {sink_lo, sink_med, sink_hi, src, pullup, ttl}
  function [5:0] drive_dec;
    input d;
    input hi;
    input lo;
    reg [2:0] m;
    begin
      m = {d, hi, lo};
      drive_dec = 6'h00;
      if (m == M_SINK_LO)
        drive_dec[5] = 1'b1;
      else if (m == M_SINK_MED)
        drive_dec[4] = 1'b1;
      else if (m == M_SINK_HI)
        drive_dec[3] = 1'b1;
      else if (d & lo)
        drive_dec[2] = 1'b1;
      else if (m == M_PULLUP)
        drive_dec[1] = 1'b1;
      drive_dec[0] = (m == M_TTL);
    end
  endfunction

  // Pin synchronisers
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pa_s1_q  <= `GDMP_RST_BYTE;
      pa_s2_q  <= `GDMP_RST_BYTE;
      pb_s1_q  <= `GDMP_RST_BYTE;
      pb_s2_q  <= `GDMP_RST_BYTE;
      aux_s1_q <= 4'h0;
      aux_s2_q <= 4'h0;
    end
    else
    begin
      pa_s1_q  <= port_a_pins_i;
      pa_s2_q  <= pa_s1_q;
      pb_s1_q  <= port_b_pins_i;
      pb_s2_q  <= pb_s1_q;
      aux_s1_q <= {usb_dp_pin_i, usb_dm_pin_i, oscillator_input_pin_i, regulator_output_pin_i};
      aux_s2_q <= aux_s1_q;
    end
  end

  // Register writes
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_a_data_q <= `GDMP_RST_BYTE;
      port_b_data_q <= `GDMP_RST_BYTE;
      pa_sel_lo_q   <= `GDMP_RST_BYTE;
      pa_sel_hi_q   <= `GDMP_RST_BYTE;
      pb_sel_lo_q   <= `GDMP_RST_BYTE;
      pb_sel_hi_q   <= `GDMP_RST_BYTE;
    end
    else if (wr)
    begin
      if (idx == `GDMP_IDX_PORT_A_DATA)
        port_a_data_q <= wb_dat_i[7:0];
      else if (idx == `GDMP_IDX_PORT_B_DATA)
        port_b_data_q <= wb_dat_i[7:0] & PB_MASK;
      else if (idx == `GDMP_IDX_PORT_A_SEL_LO)
        pa_sel_lo_q <= wb_dat_i[7:0];
      else if (idx == `GDMP_IDX_PORT_A_SEL_HI)
        pa_sel_hi_q <= wb_dat_i[7:0];
      else if (idx == `GDMP_IDX_PORT_B_SEL_LO)
        pb_sel_lo_q <= wb_dat_i[7:0] & PB_MASK;
      else if (idx == `GDMP_IDX_PORT_B_SEL_HI)
        pb_sel_hi_q <= wb_dat_i[7:0] & PB_MASK;
    end
  end

  // Read decode
  always @*
  begin
    aux_d = 8'h00;
    aux_d[`GDMP_AUX_DP_BIT]  = aux_s2_q[3];
    aux_d[`GDMP_AUX_DM_BIT]  = aux_s2_q[2];
    aux_d[`GDMP_AUX_OSC_BIT] = aux_s2_q[1] & int_clk_mode_i;
    aux_d[`GDMP_AUX_REG_BIT] = aux_s2_q[0] & ps2_mode_i;
    rd_d  = 8'h00;
    hit_d = 1'b1;
    if (idx == `GDMP_IDX_PORT_A_DATA)
      rd_d = pa_s2_q;
    else if (idx == `GDMP_IDX_PORT_B_DATA)
      rd_d = pb_s2_q & PB_MASK;
    else if (idx == `GDMP_IDX_AUX_INPUT_STATE)
      rd_d = aux_d;
    else if ((idx >= `GDMP_IDX_PORT_A_SEL_LO) && (idx <= `GDMP_IDX_PORT_B_SEL_HI))
      rd_d = 8'h00;
    else
      hit_d = 1'b0;
  end

  // Bus answer and pin drivers
  always @(posedge core_clk_i or negedge rst_n_i)
  begin : drv
    integer i;
    reg [5:0] a;
    reg [5:0] b;
    if (!rst_n_i)
    begin
      wb_dat_o          <= 32'h00000000;
      wb_ack_o          <= 1'b0;
      wb_err_o          <= 1'b0;
      port_a_pins_o     <= `GDMP_RST_BYTE;
      port_b_pins_o     <= `GDMP_RST_BYTE;
      port_a_pins_oe_o  <= `GDMP_RST_BYTE;
      port_b_pins_oe_o  <= `GDMP_RST_BYTE;
      port_a_sink_lo_o  <= `GDMP_RST_BYTE;
      port_a_sink_med_o <= `GDMP_RST_BYTE;
      port_a_sink_hi_o  <= `GDMP_RST_BYTE;
      port_a_src_o      <= `GDMP_RST_BYTE;
      port_a_pullup_o   <= `GDMP_RST_BYTE;
      port_a_ttl_o      <= `GDMP_RST_BYTE;
      port_b_sink_lo_o  <= `GDMP_RST_BYTE;
      port_b_sink_med_o <= `GDMP_RST_BYTE;
      port_b_sink_hi_o  <= `GDMP_RST_BYTE;
      port_b_src_o      <= `GDMP_RST_BYTE;
      port_b_pullup_o   <= `GDMP_RST_BYTE;
      port_b_ttl_o      <= `GDMP_RST_BYTE;
    end
    else
    begin
      wb_ack_o <= req & hit_d;
      wb_err_o <= req & ~hit_d;
      wb_dat_o <= (req & hit_d & ~wb_we_i) ? {24'h000000, rd_d} : 32'h00000000;
      for (i = 0; i < 8; i = i + 1)
      begin
        a = drive_dec(port_a_data_q[i], pa_sel_hi_q[i], pa_sel_lo_q[i]);
        b = drive_dec(port_b_data_q[i], pb_sel_hi_q[i], pb_sel_lo_q[i]);
        port_a_sink_lo_o[i]  <= a[5];
        port_a_sink_med_o[i] <= a[4];
        port_a_sink_hi_o[i]  <= a[3];
        port_a_src_o[i]      <= a[2];
        port_a_pullup_o[i]   <= a[1];
        port_a_ttl_o[i]      <= a[0];
        port_a_pins_o[i]     <= a[2];
        port_a_pins_oe_o[i]  <= a[5] | a[4] | a[3] | a[2];
        port_b_sink_lo_o[i]  <= b[5];
        port_b_sink_med_o[i] <= b[4];
        port_b_sink_hi_o[i]  <= b[3];
        port_b_src_o[i]      <= b[2];
        port_b_pullup_o[i]   <= b[1];
        port_b_ttl_o[i]      <= b[0];
        port_b_pins_o[i]     <= b[2];
        port_b_pins_oe_o[i]  <= b[5] | b[4] | b[3] | b[2];
      end
    end
  end

endmodule

// File: core/gdmp_map.vh
// Register map, reset values and field positions of the GPIO drive-mode port block.
// Assumes inclusion by the GPIO core only; definitions only.
`ifndef GDMP_MAP_VH
`define GDMP_MAP_VH

`define GDMP_IDX_PORT_A_DATA        8'h00
`define GDMP_IDX_PORT_B_DATA        8'h01
`define GDMP_IDX_AUX_INPUT_STATE    8'h02
`define GDMP_IDX_PORT_A_SEL_LO      8'h0A
`define GDMP_IDX_PORT_A_SEL_HI      8'h0B
`define GDMP_IDX_PORT_B_SEL_LO      8'h0C
`define GDMP_IDX_PORT_B_SEL_HI      8'h0D

`define GDMP_RST_BYTE               8'h00
`define GDMP_AUX_REG_BIT            0
`define GDMP_AUX_OSC_BIT            1
`define GDMP_AUX_DM_BIT             4
`define GDMP_AUX_DP_BIT             5

`define GDMP_PORT_B_BASE_MASK       8'h03
`define GDMP_PORT_B_FULL_MASK       8'hFF

`endif
